// ---- core/dwr_pkg.sv ----
/*
 dwr_pkg: constants, encodings and types of the dual wiper register block.
 Assumes a two-wire serial master on the link and a 100 MHz core clock.
*/
package dwr_pkg;

	// array shape
	localparam int CH_N = 2;
	localparam int NV_N = 4;
	localparam int WB = 6;
	localparam int TAP_N = 64;
	localparam logic [WB-1:0] WIPER_TOP = 6'h3f;

	// values after reset
	localparam logic [WB-1:0] NV_RESET = 6'h20;
	localparam logic [WB-1:0] WIPER_RESET = 6'h00;

	// fixed upper part of the slave address, pins give the low four bits
	// the value is arbitrary
	localparam logic [2:0] DEV_ID = 3'h5;

	// instruction byte fields
	localparam int OP_MSB = 7;
	localparam int OP_LSB = 4;
	localparam int CH_POS = 2;
	localparam int IDX_MSB = 1;

	// instruction codes
	localparam logic [3:0] OP_STEP = 4'h2;
	localparam logic [3:0] OP_RD_WIPER = 4'h9;
	localparam logic [3:0] OP_WR_WIPER = 4'ha;
	localparam logic [3:0] OP_RD_STORED = 4'hb;
	localparam logic [3:0] OP_WR_STORED = 4'hc;
	localparam logic [3:0] OP_LOAD = 4'hd;
	localparam logic [3:0] OP_SAVE = 4'he;

	// bit counter value of the last bit of a byte
	localparam logic [2:0] LAST_BIT = 3'h7;

	// link sequencer, gray codes along the usual path
	typedef enum logic [3:0] {
		DWR_IDLE = 4'h0,
		DWR_ADDR = 4'h1,
		DWR_ADDR_ACK = 4'h3,
		DWR_INSTR = 4'h2,
		DWR_INSTR_ACK = 4'h6,
		DWR_DATA = 4'h7,
		DWR_DATA_ACK = 4'h5,
		DWR_RDATA = 4'h4,
		DWR_RDATA_ACK = 4'hc,
		DWR_STEP = 4'hd
	} dwr_link_st_t;

	// core phase after reset
	typedef enum logic {
		DWR_RECALL = 1'b0,
		DWR_RUN = 1'b1
	} dwr_phase_t;

	// next value of a 4-bit gray counter
	function automatic logic [3:0] dwr_gray_inc(input logic [3:0] g);
		logic [3:0] b;
		b[3] = g[3];
		for (int i = 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		b = b + 4'h1;
		return b ^ (b >> 1);
	endfunction

endpackage

// ---- core/dwr_sync.sv ----
/*
 dwr_sync: two-flop synchroniser for a bundle of levels or gray bits.
 Assumes each bit is a level, a toggle or one bit of a gray counter.
*/
`timescale 1ns/1ps
module dwr_sync #(
	parameter int W = 1
) (
	// destination clock
	input wire logic clk,
	// levels in and out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	import dwr_pkg::*;

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} dwr_sync_t;

	dwr_sync_t st;
	dwr_sync_t next_st;

	// no reset: the chain flushes itself within two edges
	always_comb begin
		next_st.s1 = d;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge clk) begin
		st <= next_st;
	end

	assign q = st.s2;

endmodule // dwr_sync

// ---- core/dwr_tap_decode.sv ----
/*
 dwr_tap_decode: turns a wiper code into the one closed tap switch.
 Assumes the code comes from a register on the same clock.
*/
`timescale 1ns/1ps
module dwr_tap_decode #(
	parameter int TAPS = dwr_pkg::TAP_N
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// wiper code in, switch enables out
	input wire logic [dwr_pkg::WB-1:0] code,
	output logic [TAPS-1:0] taps
);
	import dwr_pkg::*;

	typedef struct packed {
		logic [TAPS-1:0] taps;
	} dwr_tap_t;

	dwr_tap_t st;
	dwr_tap_t next_st;
	logic [TAPS-1:0] hit;

	// one compare per tap, zero is the low end, top code the high end
	// R1 R2 R13 direct tap index
	for (genvar i = 0; i < TAPS; i++) begin : g_tap
		assign hit[i] = (code == WB'(i));
	end

	// registered so no switch glitches while the code settles
	always_comb begin
		next_st.taps = rst_n ? hit : TAPS'(1);
	end

	always_ff @(posedge ref_clk) begin
		st <= next_st;
	end

	assign taps = st.taps;

	a_tap_onehot: assert property ( // R2
		@(posedge ref_clk) disable iff (!rst_n) $onehot(taps))
		else $error("tap switches not one-hot");

	a_tap_follows: assert property ( // R1
		@(posedge ref_clk) disable iff (!rst_n)
		$past(rst_n) |-> taps == (TAPS'(1) << $past(code)))
		else $error("closed tap does not match wiper code");

endmodule // dwr_tap_decode

// ---- core/dwr_top.sv ----
/*
 dwr_top: dual wiper register bank with its two-wire serial slave.
 Assumes scl_clk is the master's serial clock, fed to a clock port,
 and an external pull-up resolving sda from sda_oe.
*/
// Behaviour
// R1 - each channel's 6-bit wiper register alone selects its closed tap
// R2 - exactly one tap per channel reaches the wiper at any time
// R3 - four 6-bit stored settings per channel, eight in total
// R4 - at power-up the first stored setting loads each wiper register
// R5 - 63 series elements give 64 selectable wiper positions
// R6 - four address pins set the device address, sixteen devices per bus
// R7 - the device responds only when the sent address matches its pins
// R8 - the data line is driven only as an open-drain output
// R9 - the master supplies the serial clock that times every transfer
// R10 - master can read and write wiper and stored registers over the bus
// R11 - instructions copy between a wiper and its own stored settings
// R12 - an instruction enters a mode that steps the wiper up or down
// R13 - wiper code 0 to 63 is the tap index, ends included
`timescale 1ns/1ps
module dwr_top (
	// core clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// serial link
	input wire logic scl_clk,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// address pins
	input wire logic addr_pin_bit0,
	input wire logic addr_pin_bit1,
	input wire logic addr_pin_bit2,
	input wire logic addr_pin_bit3,
	// potentiometer switches and wiper state
	output logic [dwr_pkg::TAP_N-1:0] tap_select_0,
	output logic [dwr_pkg::TAP_N-1:0] tap_select_1,
	output logic [dwr_pkg::WB-1:0] wiper_position_0,
	output logic [dwr_pkg::WB-1:0] wiper_position_1
);
	import dwr_pkg::*;

	typedef logic [CH_N+CH_N*NV_N-1:0][WB-1:0] dwr_img_t;

	// core domain state
	typedef struct packed {
		dwr_phase_t phase;
		logic [CH_N-1:0][WB-1:0] wiper;
		// R3 four stored settings per channel
		logic [CH_N*NV_N-1:0][WB-1:0] stored;
		logic cmd_seen;
		logic [3:0] up_seen;
		logic [3:0] dn_seen;
		dwr_img_t img;
		logic img_req;
	} dwr_core_t;

	// link domain state, rising serial clock
	typedef struct packed {
		dwr_link_st_t st;
		logic [2:0] cnt;
		logic [7:0] sh;
		logic hi_sda;
		logic start_seen;
		logic stop_seen;
		logic rd_mode;
		logic rd_wiper;
		logic ch;
		logic [1:0] idx;
		logic [3:0] cmd_op;
		logic [WB-1:0] cmd_data;
		logic cmd_tog;
		logic [3:0] up_g;
		logic [3:0] dn_g;
		logic [7:0] tx;
		logic drive;
		dwr_img_t img;
		logic img_ack;
	} dwr_link_t;

	// link domain state, falling serial clock
	typedef struct packed {
		logic start_tog;
		logic stop_tog;
		logic drive;
	} dwr_fall_t;

	dwr_core_t rf;
	dwr_core_t next_rf;
	dwr_link_t lk;
	dwr_link_t next_lk;
	dwr_fall_t fl;
	dwr_fall_t next_fl;

	logic [9:0] core_s;
	logic cmd_tog_s;
	logic img_ack_s;
	logic [3:0] up_s;
	logic [3:0] dn_s;
	logic [5:0] link_s;
	logic lk_rst_n;
	logic img_req_s;
	logic [3:0] addr_q;
	logic [7:0] rx_byte;
	logic [6:0] rx_addr;
	logic [6:0] own_addr;
	logic [7:0] rd_byte;
	logic [2:0] slot;
	logic cmd_go;
	logic step_up;
	logic step_dn;
	logic [WB-1:0] cur_wiper;
	dwr_img_t live_img;

	// crossings into the core: command toggle, step counters, image ack
	dwr_sync #(.W(10)) u_core_sync (
		.clk(ref_clk),
		.d({lk.img_ack, lk.dn_g, lk.up_g, lk.cmd_tog}),
		.q(core_s)
	);
	assign cmd_tog_s = core_s[0];
	assign up_s = core_s[4:1];
	assign dn_s = core_s[8:5];
	assign img_ack_s = core_s[9];

	// crossings into the link: reset, image request, static address pins
	dwr_sync #(.W(6)) u_link_sync (
		.clk(scl_clk),
		.d({rf.img_req, rst_n, addr_pin_bit3, addr_pin_bit2,
			addr_pin_bit1, addr_pin_bit0}),
		.q(link_s)
	);
	assign addr_q = link_s[3:0];
	assign lk_rst_n = link_s[4];
	assign img_req_s = link_s[5];

	// core side decode of a pending command or step
	assign slot = {lk.ch, lk.idx};
	assign cur_wiper = rf.wiper[lk.ch];
	assign live_img = {rf.wiper, rf.stored};
	assign cmd_go = (rf.phase == DWR_RUN) && (cmd_tog_s != rf.cmd_seen);
	assign step_up = (rf.phase == DWR_RUN) && !cmd_go
		&& (up_s != rf.up_seen);
	assign step_dn = (rf.phase == DWR_RUN) && !cmd_go && !step_up
		&& (dn_s != rf.dn_seen);

	// core registers; command fields from the link are stable while the
	// toggle crosses, since the next command needs a whole further byte
	always_comb begin
		next_rf = rf;
		if (!rst_n) begin
			next_rf = '0;
			next_rf.wiper = {CH_N{WIPER_RESET}};
			next_rf.stored = {CH_N*NV_N{NV_RESET}};
		end else begin
			// image is refreshed only once the link took the last one
			if (img_ack_s == rf.img_req && rf.img != live_img) begin
				next_rf.img = live_img;
				next_rf.img_req = ~rf.img_req;
			end
			case (rf.phase)
				// R4 power-up recall
				DWR_RECALL: begin
					for (int c = 0; c < CH_N; c++) begin
						next_rf.wiper[c] = rf.stored[c*NV_N];
					end
					next_rf.phase = DWR_RUN;
				end
				DWR_RUN: begin
					if (cmd_go) begin
						next_rf.cmd_seen = cmd_tog_s;
						case (lk.cmd_op)
							// R10 register writes
							OP_WR_WIPER: next_rf.wiper[lk.ch] = lk.cmd_data;
							OP_WR_STORED: next_rf.stored[slot] = lk.cmd_data;
							// R11 transfers within a channel
							OP_LOAD: next_rf.wiper[lk.ch] = rf.stored[slot];
							OP_SAVE: next_rf.stored[slot] = cur_wiper;
							default: next_rf.cmd_seen = cmd_tog_s;
						endcase
					end else if (step_up) begin
						// R12 step up, held at the high end
						next_rf.up_seen = dwr_gray_inc(rf.up_seen);
						if (cur_wiper != WIPER_TOP) begin
							next_rf.wiper[lk.ch] = cur_wiper + 6'h01;
						end
					end else if (step_dn) begin
						// R12 step down, held at the low end
						next_rf.dn_seen = dwr_gray_inc(rf.dn_seen);
						if (cur_wiper != 6'h00) begin
							next_rf.wiper[lk.ch] = cur_wiper - 6'h01;
						end
					end
				end
				default: next_rf.phase = DWR_RECALL;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		rf <= next_rf;
	end

	// link side decode
	assign rx_byte = {lk.sh[6:0], sda_in};
	assign rx_addr = rx_byte[7:1];
	// R6 pins form the low address bits
	assign own_addr = {DEV_ID, addr_q};
	assign rd_byte = lk.rd_wiper ? {2'b00, lk.img[{3'h4, lk.ch}]}
		: {2'b00, lk.img[{1'b0, lk.ch, lk.idx}]};

	// serial sequencer; every transfer is timed by the master's clock
	// R9 master clocks all transfers
	always_comb begin
		next_lk = lk;
		next_lk.hi_sda = sda_in;
		next_lk.sh = rx_byte;
		next_lk.cnt = lk.cnt + 3'h1;
		next_lk.drive = 1'b0;
		// a start or stop seen on the falling edge wins over a byte
		if (fl.start_tog != lk.start_seen) begin
			next_lk.start_seen = fl.start_tog;
			next_lk.st = DWR_ADDR;
			next_lk.cnt = 3'h1;
		end else if (fl.stop_tog != lk.stop_seen) begin
			next_lk.stop_seen = fl.stop_tog;
			next_lk.st = DWR_IDLE;
		end else begin
			case (lk.st)
				DWR_ADDR: begin
					// R7 take part only on a matching address
					if (lk.cnt == LAST_BIT) begin
						if (rx_addr == own_addr) begin
							next_lk.st = DWR_ADDR_ACK;
							next_lk.rd_mode = rx_byte[0];
							next_lk.drive = 1'b1;
						end else begin
							next_lk.st = DWR_IDLE;
						end
					end
				end
				DWR_ADDR_ACK: begin
					next_lk.cnt = 3'h0;
					if (lk.rd_mode) begin
						next_lk.st = DWR_RDATA;
						next_lk.drive = ~rd_byte[7];
						next_lk.tx = {rd_byte[6:0], 1'b0};
					end else begin
						next_lk.st = DWR_INSTR;
					end
				end
				DWR_INSTR: begin
					if (lk.cnt == LAST_BIT) begin
						next_lk.cmd_op = rx_byte[OP_MSB:OP_LSB];
						next_lk.ch = rx_byte[CH_POS];
						next_lk.idx = rx_byte[IDX_MSB:0];
						next_lk.rd_wiper = rx_byte[OP_MSB:OP_LSB] == OP_RD_WIPER;
						case (rx_byte[OP_MSB:OP_LSB])
							OP_STEP, OP_RD_WIPER, OP_WR_WIPER, OP_RD_STORED,
							OP_WR_STORED, OP_LOAD, OP_SAVE: begin
								next_lk.st = DWR_INSTR_ACK;
								next_lk.drive = 1'b1;
							end
							default: next_lk.st = DWR_IDLE;
						endcase
					end
				end
				DWR_INSTR_ACK: begin
					next_lk.cnt = 3'h0;
					case (lk.cmd_op)
						OP_WR_WIPER, OP_WR_STORED: next_lk.st = DWR_DATA;
						OP_RD_WIPER, OP_RD_STORED: begin
							next_lk.st = DWR_RDATA;
							next_lk.drive = ~rd_byte[7];
							next_lk.tx = {rd_byte[6:0], 1'b0};
						end
						OP_STEP: next_lk.st = DWR_STEP;
						default: begin
							next_lk.cmd_tog = ~lk.cmd_tog;
							next_lk.st = DWR_IDLE;
						end
					endcase
				end
				DWR_DATA: begin
					if (lk.cnt == LAST_BIT) begin
						next_lk.cmd_data = rx_byte[WB-1:0];
						next_lk.cmd_tog = ~lk.cmd_tog;
						next_lk.drive = 1'b1;
						next_lk.st = DWR_DATA_ACK;
					end
				end
				DWR_RDATA: begin
					// master samples this bit now, set up the next one
					if (lk.cnt == LAST_BIT) begin
						next_lk.st = DWR_RDATA_ACK;
					end else begin
						next_lk.drive = ~lk.tx[7];
						next_lk.tx = {lk.tx[6:0], 1'b0};
					end
				end
				DWR_STEP: begin
					// one step per clock: data high raises, low lowers
					if (sda_in) begin
						next_lk.up_g = dwr_gray_inc(lk.up_g);
					end else begin
						next_lk.dn_g = dwr_gray_inc(lk.dn_g);
					end
				end
				DWR_DATA_ACK, DWR_RDATA_ACK: next_lk.st = DWR_IDLE;
				default: next_lk.st = DWR_IDLE;
			endcase
		end
		// image from the core, taken on any clock of a frame
		if (img_req_s != lk.img_ack) begin
			next_lk.img = rf.img;
			next_lk.img_ack = img_req_s;
		end
		// data idles high, so a low start value would fake a stop
		if (!lk_rst_n) begin
			next_lk = '0;
			next_lk.hi_sda = 1'b1;
		end
	end

	// falling edge: data changes only while the clock is low
	always_comb begin
		next_fl = fl;
		next_fl.drive = lk.drive;
		if (lk.hi_sda && !sda_in) begin
			next_fl.start_tog = ~fl.start_tog;
		end
		if (!lk.hi_sda && sda_in) begin
			next_fl.stop_tog = ~fl.stop_tog;
		end
		if (!lk_rst_n) begin
			next_fl = '0;
		end
	end

	always_ff @(posedge scl_clk) begin
		lk <= next_lk;
	end

	always_ff @(negedge scl_clk) begin
		fl <= next_fl;
	end

	// R8 open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe = fl.drive;

	// R5 one decoder of 64 positions per channel
	logic [CH_N-1:0][TAP_N-1:0] taps;
	for (genvar c = 0; c < CH_N; c++) begin : g_ch
		dwr_tap_decode #(.TAPS(TAP_N)) u_dec (
			.ref_clk(ref_clk),
			.rst_n(rst_n),
			.code(rf.wiper[c]),
			.taps(taps[c])
		);
	end
	assign tap_select_0 = taps[0];
	assign tap_select_1 = taps[1];
	assign wiper_position_0 = rf.wiper[0];
	assign wiper_position_1 = rf.wiper[1];

	// checks, core domain
	sequence s_save;
		cmd_go && lk.cmd_op == OP_SAVE;
	endsequence
	sequence s_wr_wiper;
		cmd_go && lk.cmd_op == OP_WR_WIPER;
	endsequence

	a_recall_load: assert property ( // R4
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(rst_n) |=> rf.wiper[0] == rf.stored[0]
			&& rf.wiper[1] == rf.stored[NV_N])
		else $error("wiper not recalled from first stored setting");

	a_save_copies: assert property ( // R11
		@(posedge ref_clk) disable iff (!rst_n)
		s_save |=> rf.stored[$past(slot)] == $past(cur_wiper))
		else $error("save did not copy wiper to stored setting");

	a_write_wiper: assert property ( // R10
		@(posedge ref_clk) disable iff (!rst_n)
		s_wr_wiper |=> rf.wiper[$past(lk.ch)] == $past(lk.cmd_data))
		else $error("wiper write not applied");

	a_step_bound: assert property ( // R12
		@(posedge ref_clk) disable iff (!rst_n)
		step_up && cur_wiper == WIPER_TOP |=> $stable(rf.wiper))
		else $error("step moved wiper past the high end");

	a_nv_hold: assert property ( // R3
		@(posedge ref_clk) disable iff (!rst_n)
		!(cmd_go && (lk.cmd_op == OP_SAVE || lk.cmd_op == OP_WR_STORED))
		|=> $stable(rf.stored))
		else $error("stored setting changed without a command");

	// checks, link domain
	sequence s_rd_byte;
		(lk.st == DWR_RDATA) [*8] ##1 (lk.st == DWR_RDATA_ACK);
	endsequence

	a_addr_match: assert property ( // R7
		@(posedge scl_clk) disable iff (!lk_rst_n)
		lk.st == DWR_ADDR_ACK |-> $past(rx_addr) == $past(own_addr))
		else $error("acknowledged a foreign address");

	a_ack_drive: assert property ( // R8
		@(posedge scl_clk) disable iff (!lk_rst_n)
		lk.st == DWR_ADDR_ACK |-> sda_oe && !sda_out)
		else $error("address not acknowledged by pulling low");

	a_read_len: assert property ( // R10
		@(posedge scl_clk) disable iff (!lk_rst_n)
		$rose(lk.st == DWR_RDATA) |-> s_rd_byte)
		else $error("read byte not eight bits long");

endmodule // dwr_top

// ---- verification/dwr_master_model.sv ----
/*
 dwr_master_model: behavioural two-wire serial master for the wiper bank.
 Assumes a pull-up on the data wire and a device that only pulls it low.
*/
`timescale 1ns/1ps
module dwr_master_model (
	// serial link
	output logic scl_clk,
	output logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe
);
	logic sda_drv;

	// wired-and wire
	// pull-up resolves the shared wire, either party may only pull low
	assign sda_in = sda_drv & ~(sda_oe & ~sda_out);

	// idle bus: clock parked high, data released
	initial begin
		scl_clk = 1'b1;
		sda_drv = 1'b1;
	end

	// free pulses with data high, used only around reset
	task automatic idle_pulses(input int n);
		for (int i = 0; i < n; i++) begin
			scl_clk = 1'b0;
			#7.5;
			scl_clk = 1'b1;
			#7.5;
		end
	endtask

	// master owns the clock
	// one bit: data moves mid-low, never at the fall, where the device
	// watches for start and stop; sampled mid-high, ends low
	task automatic bit_out(input logic b, output logic s);
		#3.75;
		sda_drv = b;
		#3.75;
		scl_clk = 1'b1;
		#3.75;
		s = sda_in;
		#3.75;
		scl_clk = 1'b0;
	endtask

	// start or repeated start, detected by the device at the fall
	task automatic start();
		#3.75;
		sda_drv = 1'b1;
		#3.75;
		scl_clk = 1'b1;
		#3.75;
		sda_drv = 1'b0;
		#3.75;
		scl_clk = 1'b0;
	endtask

	// stop, then one more fall so the device sees it, clock parks high
	task automatic stop();
		#3.75;
		sda_drv = 1'b0;
		#3.75;
		scl_clk = 1'b1;
		#3.75;
		sda_drv = 1'b1;
		#3.75;
		scl_clk = 1'b0;
		#7.5;
		scl_clk = 1'b1;
		#7.5;
	endtask

	// byte transfers
	// msb first, ninth clock carries the device acknowledge
	task automatic byte_out(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_out(v[i], s);
		end
		bit_out(1'b1, s);
		ack = ~s;
	endtask

	// read byte, data line released while the device drives it
	task automatic byte_in(input logic mack, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_out(1'b1, v[i]);
		end
		bit_out(~mack, s);
	endtask
endmodule // dwr_master_model

// ---- verification/tb.sv ----
/*
 tb: self-checking bench for dwr_top, link driven by dwr_master_model.
 Assumes the opcodes, device code and reset values of dwr_pkg.
*/
`timescale 1ns/1ps
module tb;
	import dwr_pkg::*;
	typedef struct packed {
		logic [3:0] pins;
		logic ch;
		logic [5:0] val;
	} dwr_row_t;
	logic ref_clk, rst_n, scl_clk, sda_in, sda_out, sda_oe, ack;
	logic [3:0] pins;
	logic [63:0] tap0, tap1;
	logic [5:0] wp0, wp1;
	logic [7:0] rv;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	dwr_row_t rows [4] = '{'{4'h5, 1'b0, 6'h00}, '{4'ha, 1'b1, 6'h3f},
		'{4'h0, 1'b0, 6'h15}, '{4'hf, 1'b1, 6'h2a}};

	dwr_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .scl_clk(scl_clk),
		.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
		.addr_pin_bit0(pins[0]), .addr_pin_bit1(pins[1]),
		.addr_pin_bit2(pins[2]), .addr_pin_bit3(pins[3]),
		.tap_select_0(tap0), .tap_select_1(tap1),
		.wiper_position_0(wp0), .wiper_position_1(wp1));
	dwr_master_model m (.scl_clk(scl_clk), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe(sda_oe));

	// core clock
	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;

	// hang guard, the whole run needs well under 3000 cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			end_sim();
		end
	end

	task automatic check(input logic [63:0] got, input logic [63:0] exp,
		input string what);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h", $time, what, got);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// core applies a command a few cycles after the link edge
	task automatic wait_core();
		repeat (12) @(posedge ref_clk);
	endtask

	// start, address with write bit, then instruction byte, expect an acknowledge to each
	task automatic hdr(input logic ch, input logic [3:0] op,
		input logic [1:0] idx);
		m.start();
		m.byte_out({DEV_ID, pins, 1'b0}, ack);
		check(ack, 1'b1, "address ack");
		m.byte_out({op, 1'b0, ch, idx}, ack);
		check(ack, 1'b1, "instruction ack");
	endtask

	// complete write-type command, data byte only where the op has one
	task automatic cmd(input logic [3:0] op, input logic ch,
		input logic [1:0] idx, input logic dat, input logic [7:0] d);
		hdr(ch, op, idx);
		if (dat) begin
			m.byte_out(d, ack);
			check(ack, 1'b1, "data ack");
		end
		m.stop();
		wait_core();
		check(sda_oe, 1'b0, "line released");
		check(sda_out, 1'b0, "open drain level");
	endtask

	// read instruction, device answers one byte, master nacks
	task automatic rd(input logic [3:0] op, input logic ch,
		input logic [1:0] idx, output logic [7:0] v);
		wait_core();
		hdr(ch, op, idx);
		m.byte_in(1'b0, v);
		m.stop();
	endtask

	task automatic check_ch(input logic ch, input logic [5:0] v);
		check(ch ? wp1 : wp0, v, "wiper value");
		check(ch ? tap1 : tap0, 64'h1 << v, "one tap closed");
	endtask

	// reset with the link clock running, so the link side resets too
	task automatic do_reset();
		@(posedge ref_clk);
		rst_n <= 1'b0;
		fork
			m.idle_pulses(6);
			repeat (6) @(posedge ref_clk);
		join
		@(posedge ref_clk);
		rst_n <= 1'b1;
		m.idle_pulses(4);
		wait_core();
		check_ch(1'b0, NV_RESET);
		check_ch(1'b1, NV_RESET);
	endtask

	initial begin
		rst_n = 1'b0;
		pins = 4'h5;
		do_reset();
		$display("test recall done");
		// table of writes over the address range and both ends
		foreach (rows[i]) begin
			@(posedge ref_clk);
			pins <= rows[i].pins;
			@(posedge ref_clk);
			cmd(OP_WR_WIPER, rows[i].ch, 2'h0, 1'b1, {2'h0, rows[i].val});
			check_ch(rows[i].ch, rows[i].val);
		end
		$display("test table done");
		// wrong address: no ack, and the following bytes change nothing
		m.start();
		m.byte_out({DEV_ID, ~pins, 1'b0}, ack);
		check(ack, 1'b0, "foreign address");
		m.byte_out({OP_WR_WIPER, 4'h0}, ack);
		m.byte_out(8'h01, ack);
		m.stop();
		wait_core();
		check_ch(1'b0, 6'h15);
		$display("test address done");
		// stored setting written and read back, one setting on the other channel untouched
		cmd(OP_WR_STORED, 1'b1, 2'h3, 1'b1, 8'h11);
		rd(OP_RD_STORED, 1'b1, 2'h3, rv);
		check(rv, 8'h11, "stored read");
		rd(OP_RD_STORED, 1'b0, 2'h1, rv);
		check(rv, {2'h0, NV_RESET}, "stored untouched");
		rd(OP_RD_WIPER, 1'b1, 2'h0, rv);
		check(rv, 8'h2a, "wiper read");
		$display("test stored done");
		// save, overwrite, load back
		cmd(OP_WR_WIPER, 1'b0, 2'h0, 1'b1, 8'h07);
		cmd(OP_SAVE, 1'b0, 2'h2, 1'b0, 8'h00);
		cmd(OP_WR_WIPER, 1'b0, 2'h0, 1'b1, 8'h30);
		check_ch(1'b0, 6'h30);
		cmd(OP_LOAD, 1'b0, 2'h2, 1'b0, 8'h00);
		check_ch(1'b0, 6'h07);
		rd(OP_RD_STORED, 1'b0, 2'h2, rv);
		check(rv, 8'h07, "saved copy");
		// read-direction address returns the last selected register
		m.start();
		m.byte_out({DEV_ID, pins, 1'b1}, ack);
		check(ack, 1'b1, "read address ack");
		m.byte_in(1'b0, rv);
		m.stop();
		check(rv, 8'h07, "current read");
		$display("test transfer done");
		// step mode: down twice, up into the top, repeated start ends it
		cmd(OP_WR_WIPER, 1'b0, 2'h0, 1'b1, 8'h3e);
		hdr(1'b0, OP_STEP, 2'h0);
		for (int i = 0; i < 6; i++) begin
			m.bit_out(i > 1, ack);
		end
		m.start();
		m.stop();
		wait_core();
		check_ch(1'b0, 6'h3f);
		check_ch(1'b1, 6'h2a);
		// down into the bottom, the stop's own edge steps once more
		cmd(OP_WR_WIPER, 1'b0, 2'h0, 1'b1, 8'h01);
		hdr(1'b0, OP_STEP, 2'h0);
		m.bit_out(1'b0, ack);
		m.bit_out(1'b0, ack);
		m.stop();
		wait_core();
		check_ch(1'b0, 6'h00);
		$display("test step done");
		// reset in mid-run: wipers recalled, stored settings back too
		do_reset();
		rd(OP_RD_STORED, 1'b0, 2'h2, rv);
		check(rv, {2'h0, NV_RESET}, "stored after reset");
		$display("test reset done");
		end_sim();
	end
endmodule // tb
